// [nmi_halt_consts.svh]
// Constants for the interrupt, halt and reset control of the processor core
`ifndef NMI_HALT_CONSTS_SVH
`define NMI_HALT_CONSTS_SVH

`define NMI_VECTOR        16'h0066
`define RESET_VECTOR      16'h0000
`define DUMMY_STATES      3'h2
`define ADDR_ZERO         16'h0000
`define DATA_ZERO         8'h00

`endif

// [nmi_halt_pkg.sv]
// Types for the interrupt, halt and reset control of the processor core
package nmi_halt_pkg;

    typedef enum logic [5:0] {
        ST_DUMMY  = 6'h01,
        ST_RUN    = 6'h02,
        ST_NMI_M1 = 6'h04,
        ST_PUSH   = 6'h08,
        ST_VECTOR = 6'h10,
        ST_HALT   = 6'h20
    } ctl_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        memory_request_n;
        logic        io_request_n;
        logic        read_n;
        logic        write_n;
        logic        halt_n;
        logic        fetch_cycle_indicator_n;
        logic        dram_refresh_strobe_n;
    } bus_pins_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        memory_request_n;
        logic        io_request_n;
        logic        read_n;
        logic        write_n;
        logic        fetch_cycle_indicator_n;
        logic        dram_refresh_strobe_n;
    } core_bus_t;

    typedef struct packed {
        ctl_state_t  state;
        logic        nmi_in_d;
        logic        nmi_pending;
        logic [2:0]  dummy_cnt;
        logic [1:0]  push_cnt;
        logic        halted;
        logic        nmi_taken;
        logic        int_taken;
        logic        pc_load;
        logic [15:0] pc_value;
        logic        push_pc;
        logic        discard_opcode;
        logic        nop_force;
        logic        fetch_enable;
        bus_pins_t   pins_out;
        logic        pins_oe_n;
    } ctl_regs_t;

endpackage

// [nmi_halt_reset_control.sv]
// Non-maskable acknowledge, halt, reset start-up and evaluation float control
// Notes on behaviour
// - Falling edge on non-maskable request sets pending flop, any time.
// - Pending flop is sampled only at the last state of each instruction.
// - Acknowledge runs a normal opcode fetch and discards the fetched byte.
// - Program counter is pushed onto the stack in machine cycles two and three.
// - Then the program counter loads the fixed non-maskable vector.
// - Halted indication goes low at T4 of the halt instruction fetch.
// - While halted, no-operation fetches with refresh repeat, data ignored.
// - Halt ends only on an accepted interrupt or on reset.
// - While halted, interrupts are sampled at T4 of each no-operation cycle.
// - Maskable request leaves halt only if low and enable flop is one.
// - Servicing of an accepted interrupt begins in the next machine cycle.
// - After reset, a dummy cycle of two or more states, then fetch from zero.
// - Evaluation input with bus hold floats address, data, strobes, halt, refresh.
// - No interrupts are accepted while the bus is floated.
`timescale 1ns/1ps
`default_nettype none
`include "nmi_halt_consts.svh"

module nmi_halt_reset_control
    import nmi_halt_pkg::*;
#(
    parameter int DUMMY_STATES = 2,
    parameter int PUSH_CYCLES  = 2
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        nmi_request_n,
    input  wire logic        int_request_n,
    input  wire logic        interrupt_enable_flop,
    input  wire logic        bus_hold_request_n,
    input  wire logic        evaluation_float_in,
    input  wire logic        instr_last_state,
    input  wire logic        halt_fetched_t4,
    input  wire logic        machine_cycle_end,
    input  wire core_bus_t   core_bus,
    output var  bus_pins_t   pins_out,
    output logic             pins_oe_n,
    output logic             halt_n,
    output logic             fetch_enable,
    output logic             nmi_taken,
    output logic             int_taken,
    output logic             discard_opcode,
    output logic             nop_force,
    output logic             push_pc,
    output logic             pc_load,
    output logic [15:0]      pc_value
);

    ctl_regs_t r;
    ctl_regs_t next_r;

    logic floated;
    logic nmi_fall;
    logic boundary;
    logic take_nmi;
    logic take_int;

    always_comb begin
        next_r = r;
        floated  = !bus_hold_request_n;
        nmi_fall = r.nmi_in_d && !nmi_request_n;
        // Instruction end, or T4 of each no-operation cycle while halted
        boundary = instr_last_state;
        // Floated bus blocks both kinds; maskable also needs the enable flop
        take_nmi = boundary && r.nmi_pending && !floated;
        take_int = boundary && !r.nmi_pending && !int_request_n
                   && interrupt_enable_flop && !floated;

        next_r.nmi_in_d  = nmi_request_n;
        next_r.nmi_taken = 1'b0;
        next_r.int_taken = 1'b0;
        next_r.pc_load   = 1'b0;
        next_r.push_pc   = 1'b0;
        next_r.discard_opcode = 1'b0;

        // Edge set wins over the acknowledge clear
        if (nmi_fall) begin
            next_r.nmi_pending = 1'b1;
        end else if (take_nmi && r.state inside {ST_RUN, ST_HALT}) begin
            next_r.nmi_pending = 1'b0;
        end

        unique case (r.state)
            ST_DUMMY: begin
                next_r.fetch_enable = 1'b0;
                if (r.dummy_cnt >= 3'(DUMMY_STATES - 1)) begin
                    next_r.state        = ST_RUN;
                    next_r.fetch_enable = 1'b1;
                    next_r.pc_load      = 1'b1;
                    next_r.pc_value     = `RESET_VECTOR;
                end else begin
                    next_r.dummy_cnt = r.dummy_cnt + 3'h1;
                end
            end
            ST_RUN: begin
                if (take_nmi) begin
                    next_r.state          = ST_NMI_M1;
                    next_r.nmi_taken      = 1'b1;
                    next_r.discard_opcode = 1'b1;
                end else if (take_int) begin
                    next_r.int_taken = 1'b1;
                end else if (halt_fetched_t4) begin
                    next_r.state     = ST_HALT;
                    next_r.halted    = 1'b1;
                    next_r.nop_force = 1'b1;
                end
            end
            ST_NMI_M1: begin
                next_r.discard_opcode = 1'b1;
                if (machine_cycle_end) begin
                    next_r.state          = ST_PUSH;
                    next_r.discard_opcode = 1'b0;
                    next_r.push_pc        = 1'b1;
                    next_r.push_cnt       = 2'h0;
                end
            end
            ST_PUSH: begin
                next_r.push_pc = 1'b1;
                if (machine_cycle_end) begin
                    if (r.push_cnt >= 2'(PUSH_CYCLES - 1)) begin
                        next_r.state    = ST_VECTOR;
                        next_r.push_pc  = 1'b0;
                        next_r.pc_load  = 1'b1;
                        next_r.pc_value = `NMI_VECTOR;
                    end else begin
                        next_r.push_cnt = r.push_cnt + 2'h1;
                    end
                end
            end
            ST_VECTOR: begin
                next_r.state = ST_RUN;
            end
            ST_HALT: begin
                // Data bus is ignored by the core while nop_force holds
                next_r.nop_force = 1'b1;
                if (take_nmi || take_int) begin
                    next_r.halted    = 1'b0;
                    next_r.nop_force = 1'b0;
                    next_r.nmi_taken = take_nmi;
                    next_r.int_taken = take_int;
                    next_r.discard_opcode = take_nmi;
                    next_r.state     = take_nmi ? ST_NMI_M1 : ST_RUN;
                end
            end
        endcase

        next_r.pins_out.addr                    = core_bus.addr;
        next_r.pins_out.data                    = core_bus.data;
        next_r.pins_out.memory_request_n        = core_bus.memory_request_n;
        next_r.pins_out.io_request_n            = core_bus.io_request_n;
        next_r.pins_out.read_n                  = core_bus.read_n;
        next_r.pins_out.write_n                 = core_bus.write_n;
        next_r.pins_out.halt_n                  = !next_r.halted;
        next_r.pins_out.fetch_cycle_indicator_n = core_bus.fetch_cycle_indicator_n;
        // No refresh while floated
        next_r.pins_out.dram_refresh_strobe_n   = floated ? 1'b1
                                                : core_bus.dram_refresh_strobe_n;
        // Float all listed pins in evaluation mode with bus hold
        next_r.pins_oe_n = evaluation_float_in && floated;
    end

    // Reset holds everything at start-up values; the core restarts from dummy
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r.state          <= ST_DUMMY;
            r.nmi_in_d       <= 1'b1;
            r.nmi_pending    <= 1'b0;
            r.dummy_cnt      <= 3'h0;
            r.push_cnt       <= 2'h0;
            r.halted         <= 1'b0;
            r.nmi_taken      <= 1'b0;
            r.int_taken      <= 1'b0;
            r.pc_load        <= 1'b0;
            r.pc_value       <= `ADDR_ZERO;
            r.push_pc        <= 1'b0;
            r.discard_opcode <= 1'b0;
            r.nop_force      <= 1'b0;
            r.fetch_enable   <= 1'b0;
            r.pins_out       <= '1;
            r.pins_oe_n      <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign pins_out       = r.pins_out;
    assign pins_oe_n      = r.pins_oe_n;
    assign halt_n         = r.pins_out.halt_n;
    assign fetch_enable   = r.fetch_enable;
    assign nmi_taken      = r.nmi_taken;
    assign int_taken      = r.int_taken;
    assign discard_opcode = r.discard_opcode;
    assign nop_force      = r.nop_force;
    assign push_pc        = r.push_pc;
    assign pc_load        = r.pc_load;
    assign pc_value       = r.pc_value;

endmodule // nmi_halt_reset_control

`default_nettype wire

// [nmi_halt_reset_control_chk.sv]
// Assertion checker for the interrupt, halt and reset control
`timescale 1ns/1ps
`default_nettype none
module nmi_halt_reset_control_chk #(
    parameter int DUMMY_STATES = 2,
    parameter int PUSH_CYCLES  = 2
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        int_request_n,
    input wire logic        interrupt_enable_flop,
    input wire logic        bus_hold_request_n,
    input wire logic        evaluation_float_in,
    input wire logic        instr_last_state,
    input wire logic        halt_fetched_t4,
    input wire logic        pins_oe_n,
    input wire logic        halt_n,
    input wire logic        fetch_enable,
    input wire logic        nmi_taken,
    input wire logic        int_taken,
    input wire logic        discard_opcode,
    input wire logic        nop_force,
    input wire logic        push_pc,
    input wire logic        pc_load,
    input wire logic [15:0] pc_value
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_nmi_boundary: assert property (nmi_taken |-> $past(instr_last_state))
        else $error("nmi taken off boundary");
    chk_int_gate: assert property (
        int_taken |-> $past(!int_request_n && interrupt_enable_flop && instr_last_state))
        else $error("int taken while gated");
    chk_no_take_held: assert property (
        !bus_hold_request_n |=> !nmi_taken && !int_taken) else $error("taken while held");
    chk_ack_once: assert property (nmi_taken |-> discard_opcode ##1 !nmi_taken)
        else $error("bad nmi ack");
    chk_vector_load: assert property (
        $fell(push_pc) |-> pc_load && pc_value == 16'h0066) else $error("bad vector");
    chk_halt_entry: assert property (
        halt_fetched_t4 && fetch_enable |=> !halt_n && nop_force) else $error("no halt");
    chk_halt_exit: assert property ($rose(halt_n) |-> nmi_taken || int_taken)
        else $error("halt left without interrupt");
    chk_float_pins: assert property (
        evaluation_float_in && !bus_hold_request_n |=> pins_oe_n) else $error("not floated");
    chk_start_fetch: assert property (
        $rose(reset_n) |-> !fetch_enable ##1 !fetch_enable ##[1:2] fetch_enable && pc_load
        && pc_value == 16'h0000) else $error("bad start-up");
    cov_nmi: cover property (nmi_taken);
    cov_int: cover property (int_taken);
    cov_float: cover property (pins_oe_n);
endmodule // nmi_halt_reset_control_chk

bind nmi_halt_reset_control nmi_halt_reset_control_chk #(.DUMMY_STATES(DUMMY_STATES),
    .PUSH_CYCLES(PUSH_CYCLES)) i_chk (.clk, .reset_n, .int_request_n, .interrupt_enable_flop,
    .bus_hold_request_n, .evaluation_float_in, .instr_last_state, .halt_fetched_t4, .pins_oe_n,
    .halt_n, .fetch_enable, .nmi_taken, .int_taken, .discard_opcode, .nop_force, .push_pc,
    .pc_load, .pc_value);
`default_nettype wire

// [nmi_halt_reset_control_tb.sv]
// Self-checking bench for the interrupt, halt and reset control
`timescale 1ns/1ps
`default_nettype none
module nmi_halt_reset_control_tb;
    import nmi_halt_pkg::*;
    logic        clk = 0, reset_n = 0, ie = 0, hold_n = 1, ev = 0, ils = 0, hft = 0, mce = 0;
    logic        fire = 0, hold_int = 0, nmi_n, int_n, oe_n, halt_n, fe, nmi_tk, int_tk, pcl;
    logic        disc, nopf, psh;
    logic [15:0] pcv, last_addr = 16'h0000, vec_q[$];
    logic [31:0] seed = 32'h6AC1;
    core_bus_t   cbus = '0;
    bus_pins_t   pins;
    int          failures = 0, total_checks = 0, exp_nmi = 0, exp_int = 0;
    int          nmi_cnt = 0, int_cnt = 0, push_seen = 0;
    always #5 clk = ~clk;
    nmi_halt_src i_src (.clk, .fire_nmi(fire), .hold_int, .nmi_request_n(nmi_n),
        .int_request_n(int_n));
    nmi_halt_reset_control #(.DUMMY_STATES(2), .PUSH_CYCLES(2)) i_dut (.clk, .reset_n,
        .nmi_request_n(nmi_n), .int_request_n(int_n), .interrupt_enable_flop(ie),
        .bus_hold_request_n(hold_n), .evaluation_float_in(ev), .instr_last_state(ils),
        .halt_fetched_t4(hft), .machine_cycle_end(mce), .core_bus(cbus), .pins_out(pins),
        .pins_oe_n(oe_n), .halt_n, .fetch_enable(fe), .nmi_taken(nmi_tk), .int_taken(int_tk),
        .discard_opcode(disc), .nop_force(nopf), .push_pc(psh), .pc_load(pcl), .pc_value(pcv));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cyc(input logic l, input logic h, input logic m);
        @(negedge clk);
        if (fe && !oe_n) check(pins.addr, last_addr);
        ils = l;
        hft = h;
        mce = m;
        cbus = core_bus_t'(30'(rnd()));
        last_addr = cbus.addr;
    endtask
    task automatic run(input int n, input logic l, input logic h);
        repeat (n - 1) cyc(0, 0, 0);
        cyc(l, h, 1);
    endtask
    task automatic ack();
        exp_nmi++;
        vec_q.push_back(16'h0066);
        run(4, 0, 0);
        run(3, 0, 0);
        run(3, 0, 0);
        run(4, 1, 0);
    endtask
    task automatic nmi_at(input int pre);
        repeat (pre) cyc(0, 0, 0);
        fire = 1;
        cyc(0, 0, 0);
        fire = 0;
        cyc(1, 0, 1);
        ack();
    endtask
    task automatic end_test(input string name);
        // Third edge lets the last load pulse be counted
        repeat (3) cyc(0, 0, 0);
        check(16'(nmi_cnt), 16'(exp_nmi));
        check(16'(push_seen), 16'(2 * exp_nmi));
        check(16'(int_cnt), 16'(exp_int));
        check(16'(vec_q.size()), 16'h0000);
        $display("test %s done", name);
    endtask
    task automatic wrap_up();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Registered pulses read before the edge updates them
    always @(posedge clk) begin
        if (reset_n && nmi_tk) nmi_cnt++;
        if (reset_n && int_tk) int_cnt++;
        if (reset_n && psh && mce) push_seen++;
        if (reset_n && nmi_tk) check({15'h0, disc}, 16'h0001);
        if (reset_n && pcl) check(pcv, vec_q.size() > 0 ? vec_q.pop_front() : 16'hFFFF);
    end
    initial begin
        #20us;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (5) cyc(0, 0, 0);
        vec_q.push_back(16'h0000);
        reset_n = 1;
        end_test("reset");
        for (int i = 0; i < 4; i++) nmi_at(int'(rnd() % 3));
        end_test("nmi");
        hold_n = 0;
        fire = 1;
        cyc(0, 0, 0);
        fire = 0;
        run(3, 1, 0);
        repeat (2) cyc(0, 0, 0);
        check(16'(nmi_cnt), 16'(exp_nmi));
        hold_n = 1;
        cyc(1, 0, 1);
        ack();
        end_test("held");
        hold_int = 1;
        run(4, 1, 1);
        run(4, 1, 0);
        check({15'h0, halt_n}, 16'h0000);
        check({15'h0, nopf}, 16'h0001);
        // Enable flop is a bench input: drop it after the one acceptance
        ie = 1;
        exp_int++;
        cyc(0, 0, 0);
        hold_int = 0;
        ie = 0;
        run(4, 1, 0);
        run(3, 0, 0);
        check({15'h0, halt_n}, 16'h0001);
        check({15'h0, nopf}, 16'h0000);
        run(4, 1, 1);
        nmi_at(1);
        check({15'h0, halt_n}, 16'h0001);
        end_test("halt");
        ev = 1;
        hold_n = 0;
        repeat (2) cyc(0, 0, 0);
        check({15'h0, oe_n}, 16'h0001);
        ev = 0;
        hold_n = 1;
        repeat (2) cyc(0, 0, 0);
        check({15'h0, oe_n}, 16'h0000);
        end_test("float");
        wrap_up();
    end
endmodule // nmi_halt_reset_control_tb
`default_nettype wire

// [nmi_halt_src.sv]
// Interrupt source model driving both request lines
`timescale 1ns/1ps
`default_nettype none
module nmi_halt_src (
    input  wire logic clk,
    input  wire logic fire_nmi,
    input  wire logic hold_int,
    output logic      nmi_request_n = 1'b1,
    output logic      int_request_n = 1'b1
);
    int low_cnt = 0;
    // Two-clock pulse so the edge is seen well before the boundary
    always @(posedge clk) begin
        if (fire_nmi) low_cnt = 2;
        else if (low_cnt > 0) low_cnt = low_cnt - 1;
        nmi_request_n <= (low_cnt == 0);
        int_request_n <= !hold_int;
    end
endmodule // nmi_halt_src
`default_nettype wire
